// [common/i2c_tx_pkg.sv]
package i2c_tx_pkg;

    // register byte offsets on the apb side
    localparam logic [7:0] OFF_SHARED0 = 8'h00;
    localparam logic [7:0] OFF_SHARED1 = 8'h04;
    localparam logic [7:0] OFF_CTRL    = 8'h08;
    localparam logic [7:0] OFF_STAT    = 8'h0c;
    localparam logic [7:0] OFF_TIMER   = 8'h10;
    localparam int         RANGE_BIT   = 5;
    localparam logic [7:0] REG_RST     = 8'h00;

    // serial clock selection and rates
    localparam logic [2:0]  CLK_SEL_STD = 3'h5;
    localparam int          LINK_HZ     = 166_666_666;
    localparam int          SCL_STD_HZ  = 100_000;
    localparam int          SCL_SLOW_HZ = 50_000;
    localparam logic [11:0] QTR_STD     = 12'(LINK_HZ / (4 * SCL_STD_HZ));
    localparam logic [11:0] QTR_SLOW    = 12'(LINK_HZ / (4 * SCL_SLOW_HZ));

    // bits per frame: data plus acknowledge, or data alone
    localparam logic [3:0] BITS_STD = 4'h9;
    localparam logic [3:0] BITS_RAW = 4'h8;
    localparam logic [1:0] PH_LAST  = 2'h3;

    typedef struct packed {
        logic iface_enable;
        logic irq_enable;
        logic master_sel;
        logic tx_sel;
        logic ack_check_en;
        logic bus_busy;
        logic irq_flag;
        logic start_stop_ctl;
    } ctrl_t;

    typedef struct packed {
        logic       msb_first;
        logic       wait_en;
        logic [2:0] clk_sel;
        logic [2:0] bit_cnt;
    } mode_t;

    typedef enum logic [4:0] {
        L_IDLE  = 5'h01,
        L_START = 5'h02,
        L_BIT   = 5'h04,
        L_HOLD  = 5'h08,
        L_STOP  = 5'h10
    } link_state_t;

    // quarter serial period in link clocks
    function automatic logic [11:0] qtr_count(input logic range, input logic [2:0] sel);
        return (range && sel == CLK_SEL_STD) ? QTR_STD : QTR_SLOW;
    endfunction : qtr_count

endpackage : i2c_tx_pkg

// [design/i2c_tx_ctl.sv]
//
// Contract
// - enable low: shared offsets reach slave address and extended address
// - enable high: shared offsets reach bus mode and data registers
// - both format bits zero: standard format with acknowledge slot
// - range bit 1 and clock select 101 give a 100 kHz serial clock
// - wait bit zero: data bits and acknowledge run without pause
// - acknowledge check on: a nack halts further continuous transfer
// - interrupt enable low: no interrupt, flag may still set
// - master and transmit bits both set select master transmission
// - busy 1 with start/stop 0 written issues a start condition
// - flag sets when the start is seen on the bus lines
// - flag sets when a transmit byte has finished on the bus
// - busy 0 with start/stop 0 written issues a stop condition
// - busy bit shows bus occupied; with start/stop it requests conditions
// - enable low releases the pins; enable high drives the bus
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module i2c_tx_ctl (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        clk_link,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);
    // ---------------- system domain ----------------
    i2c_tx_pkg::ctrl_t ctrl, next_ctrl;
    i2c_tx_pkg::mode_t mode, next_mode;
    logic [7:0]  data, next_data, sar, next_sar, sarx, next_sarx;
    logic        range, next_range, ack_bit, next_ack_bit;
    logic [31:0] next_prdata;
    logic        start_tgl, next_start_tgl, stop_tgl, next_stop_tgl;
    logic        send_tgl, next_send_tgl;
    logic        sdone_d, bdone_d;
    logic        busy_s1, busy_s2, ack_s1, ack_s2, sack_s1, sack_s2;
    logic        sdone_s1, sdone_s2, bdone_s1, bdone_s2;
    logic        wr, start_evt, byte_evt, halted, pending;
    i2c_tx_pkg::ctrl_t w, rc;
    logic [7:0]  rd;
    // link-side registers read back across the crossing
    logic        busy, sdone_tgl, bdone_tgl, ack_l, send_ack;

    // single-cycle access phase, no errors
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irq     = ctrl.irq_flag & ctrl.irq_enable;

    // link status into the system clock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {busy_s1, busy_s2, ack_s1, ack_s2, sack_s1, sack_s2} <= 6'h00;
            {sdone_s1, sdone_s2, bdone_s1, bdone_s2} <= 4'h0;
        end else begin
            {busy_s1, busy_s2} <= {busy, busy_s1};
            {ack_s1, ack_s2}   <= {ack_l, ack_s1};
            {sack_s1, sack_s2} <= {send_ack, sack_s1};
            {sdone_s1, sdone_s2} <= {sdone_tgl, sdone_s1};
            {bdone_s1, bdone_s2} <= {bdone_tgl, bdone_s1};
        end
    end

    // register file next values
    always_comb begin
        w = i2c_tx_pkg::ctrl_t'(pwdata[7:0]);
        rc = ctrl;
        rd = i2c_tx_pkg::REG_RST;
        wr = psel & penable & pwrite;
        start_evt = sdone_s2 ^ sdone_d;
        byte_evt  = bdone_s2 ^ bdone_d;
        halted  = ctrl.ack_check_en & ack_bit;
        pending = send_tgl ^ sack_s2;            // data held until link takes it
        next_ctrl = ctrl;
        next_mode = mode;
        next_data = data;
        next_sar = sar;
        next_sarx = sarx;
        next_range = range;
        next_ack_bit = ack_bit;
        next_start_tgl = start_tgl;
        next_stop_tgl = stop_tgl;
        next_send_tgl = send_tgl;
        if (wr) begin
            unique case (paddr)
                i2c_tx_pkg::OFF_SHARED0: begin
                    if (ctrl.iface_enable) begin
                        next_mode = i2c_tx_pkg::mode_t'(pwdata[7:0]);
                    end else begin
                        next_sar = pwdata[7:0];
                    end
                end
                i2c_tx_pkg::OFF_SHARED1: begin
                    if (!ctrl.iface_enable) begin
                        next_sarx = pwdata[7:0];
                    end else if (!pending) begin
                        next_data = pwdata[7:0];
                        // a nack under acknowledge check refuses the next byte
                        if (ctrl.master_sel && ctrl.tx_sel && busy_s2 && !halted) begin
                            next_send_tgl = ~send_tgl;
                        end
                    end
                end
                i2c_tx_pkg::OFF_CTRL: begin
                    next_ctrl = w;
                    next_ctrl.bus_busy = 1'b0;
                    next_ctrl.irq_flag = ctrl.irq_flag & w.irq_flag;
                    if (w.iface_enable && w.master_sel && w.tx_sel && w.bus_busy
                        && !w.start_stop_ctl && !busy_s2) begin
                        next_start_tgl = ~start_tgl;
                    end
                    if (w.iface_enable && !w.bus_busy && !w.start_stop_ctl && busy_s2) begin
                        next_stop_tgl = ~stop_tgl;
                    end
                end
                i2c_tx_pkg::OFF_STAT:  next_ack_bit = ack_bit & pwdata[0];
                i2c_tx_pkg::OFF_TIMER: next_range = pwdata[i2c_tx_pkg::RANGE_BIT];
                default: ;
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (start_evt || byte_evt) begin
            next_ctrl.irq_flag = 1'b1;
        end
        if (byte_evt) begin
            next_ack_bit = ack_s2;
        end
        rc.bus_busy = busy_s2;
        unique case (paddr)
            i2c_tx_pkg::OFF_SHARED0: rd = ctrl.iface_enable ? mode : sar;
            i2c_tx_pkg::OFF_SHARED1: rd = ctrl.iface_enable ? data : sarx;
            i2c_tx_pkg::OFF_CTRL:    rd = rc;
            i2c_tx_pkg::OFF_STAT:    rd = {7'h00, ack_bit};
            i2c_tx_pkg::OFF_TIMER:   rd = {2'h0, range, 5'h00};
            default:                 rd = i2c_tx_pkg::REG_RST;
        endcase
        next_prdata = (psel && !penable && !pwrite) ? {24'h000000, rd} : prdata;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl <= i2c_tx_pkg::ctrl_t'(i2c_tx_pkg::REG_RST);
            mode <= i2c_tx_pkg::mode_t'(i2c_tx_pkg::REG_RST);
            {data, sar, sarx} <= {3{i2c_tx_pkg::REG_RST}};
            {range, ack_bit, start_tgl, stop_tgl, send_tgl} <= 5'h00;
            {sdone_d, bdone_d} <= 2'h0;
            prdata <= 32'h00000000;
        end else begin
            ctrl <= next_ctrl;
            mode <= next_mode;
            data <= next_data;
            sar  <= next_sar;
            sarx <= next_sarx;
            range <= next_range;
            ack_bit <= next_ack_bit;
            start_tgl <= next_start_tgl;
            stop_tgl  <= next_stop_tgl;
            send_tgl  <= next_send_tgl;
            sdone_d <= sdone_s2;
            bdone_d <= bdone_s2;
            prdata <= next_prdata;
        end
    end

    // ---------------- link domain ----------------
    i2c_tx_pkg::link_state_t st, next_st;
    logic [1:0]  ph, next_ph;
    logic [11:0] qcnt, next_qcnt, qtr;
    logic [3:0]  bitn, next_bitn, nbits;
    logic [8:0]  shreg, next_shreg;
    logic        next_busy, next_sdone_tgl, next_bdone_tgl, next_ack_l, next_send_ack;
    logic        start_ack, next_start_ack, stop_ack, next_stop_ack;
    logic        scl_low, next_scl_low, sda_low, next_sda_low;
    logic        tick, sda_d;
    logic [5:0]  cfg_s1, cfg_s2;
    logic [2:0]  cmd_s1, cmd_s2;
    logic [1:0]  pin_s1, pin_s2;
    logic        en_l, fmt_std;

    // static config and command toggles, two flops each
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            {cfg_s1, cfg_s2} <= 12'h000;
            {cmd_s1, cmd_s2} <= 6'h00;
            {pin_s1, pin_s2} <= 4'hf;
        end else begin
            cfg_s1 <= {ctrl.iface_enable, !(sar[0] | sarx[0]), range, mode.clk_sel};
            cfg_s2 <= cfg_s1;
            cmd_s1 <= {start_tgl, stop_tgl, send_tgl};
            cmd_s2 <= cmd_s1;
            pin_s1 <= {scl_in, sda_in};
            pin_s2 <= pin_s1;
        end
    end

    assign en_l    = cfg_s2[5];
    assign fmt_std = cfg_s2[4];
    assign qtr     = i2c_tx_pkg::qtr_count(cfg_s2[3], cfg_s2[2:0]);
    assign nbits   = fmt_std ? i2c_tx_pkg::BITS_STD : i2c_tx_pkg::BITS_RAW;
    assign tick    = (qcnt == 12'h000);
    // open drain: drive low only, released while the interface is off
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = en_l & scl_low;
    assign sda_oe  = en_l & sda_low;

    // bit engine: four quarter phases per serial bit
    always_comb begin
        next_st = st;
        next_ph = ph;
        next_qcnt = tick ? qtr : qcnt - 12'h001;
        next_bitn = bitn;
        next_shreg = shreg;
        next_busy = busy;
        next_ack_l = ack_l;
        next_bdone_tgl = bdone_tgl;
        next_start_ack = start_ack;
        next_stop_ack = stop_ack;
        next_send_ack = send_ack;
        next_scl_low = scl_low;
        next_sda_low = sda_low;
        // start seen from line levels: sda falls while scl high
        next_sdone_tgl = sdone_tgl ^ (busy & pin_s2[1] & sda_d & !pin_s2[0]);
        unique case (st)
            i2c_tx_pkg::L_IDLE: begin
                next_qcnt = qtr;
                if (en_l && cmd_s2[2] != start_ack) begin
                    next_start_ack = cmd_s2[2];
                    next_busy = 1'b1;
                    next_ph = 2'h0;
                    next_st = i2c_tx_pkg::L_START;
                end
            end
            i2c_tx_pkg::L_START: if (tick) begin
                next_ph = ph + 2'h1;
                unique case (ph)
                    2'h0:    next_sda_low = 1'b1;
                    2'h1:    next_scl_low = 1'b1;
                    default: next_st = i2c_tx_pkg::L_HOLD;
                endcase
            end
            i2c_tx_pkg::L_HOLD: begin
                if (cmd_s2[0] != send_ack) begin
                    next_send_ack = cmd_s2[0];
                    next_shreg = {data, 1'b1};
                    next_sda_low = !data[7];
                    next_bitn = 4'h0;
                    next_ph = 2'h0;
                    next_ack_l = 1'b0;
                    next_st = i2c_tx_pkg::L_BIT;
                end else if (cmd_s2[1] != stop_ack) begin
                    next_stop_ack = cmd_s2[1];
                    next_sda_low = 1'b1;
                    next_ph = 2'h0;
                    next_st = i2c_tx_pkg::L_STOP;
                end
            end
            i2c_tx_pkg::L_BIT: if (tick) begin
                next_ph = ph + 2'h1;
                unique case (ph)
                    2'h0: next_scl_low = 1'b0;
                    2'h1: if (fmt_std && bitn == i2c_tx_pkg::BITS_RAW) begin
                        next_ack_l = pin_s2[0];
                    end
                    2'h2: next_scl_low = 1'b1;
                    default: begin
                        // acknowledge slot follows data with no pause
                        if (bitn == nbits - 4'h1) begin
                            next_bdone_tgl = ~bdone_tgl;
                            next_sda_low = 1'b0;
                            next_st = i2c_tx_pkg::L_HOLD;
                        end else begin
                            next_bitn = bitn + 4'h1;
                            next_shreg = {shreg[7:0], 1'b1};
                            next_sda_low = !shreg[7];
                        end
                    end
                endcase
            end
            i2c_tx_pkg::L_STOP: if (tick) begin
                next_ph = ph + 2'h1;
                unique case (ph)
                    2'h0: next_scl_low = 1'b0;
                    2'h1: next_sda_low = 1'b0;
                    default: begin
                        next_busy = 1'b0;
                        next_st = i2c_tx_pkg::L_IDLE;
                    end
                endcase
            end
            default: next_st = i2c_tx_pkg::L_IDLE;
        endcase
    end

    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            st <= i2c_tx_pkg::L_IDLE;
            ph <= 2'h0;
            qcnt <= 12'h000;
            bitn <= 4'h0;
            shreg <= 9'h1ff;
            {busy, sdone_tgl, bdone_tgl, ack_l, send_ack} <= 5'h00;
            {start_ack, stop_ack, scl_low, sda_low} <= 4'h0;
            sda_d <= 1'b1;
        end else begin
            st <= next_st;
            ph <= next_ph;
            qcnt <= next_qcnt;
            bitn <= next_bitn;
            shreg <= next_shreg;
            busy <= next_busy;
            sdone_tgl <= next_sdone_tgl;
            bdone_tgl <= next_bdone_tgl;
            ack_l <= next_ack_l;
            send_ack <= next_send_ack;
            start_ack <= next_start_ack;
            stop_ack <= next_stop_ack;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
            sda_d <= pin_s2[0];
        end
    end

    // ---------------- checks ----------------
    irq_mask_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ctrl.irq_enable |-> !irq) else $error("irq raised while disabled");
    irq_raise_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl.irq_flag && ctrl.irq_enable |-> irq) else $error("irq missing");
    start_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        start_evt |=> ctrl.irq_flag) else $error("start did not set flag");
    byte_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        byte_evt |=> ctrl.irq_flag && ack_bit == $past(ack_s2)) else $error("byte end lost");
    addr_route_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr && paddr == i2c_tx_pkg::OFF_SHARED0 && !ctrl.iface_enable
        |=> $stable(mode) && sar == $past(pwdata[7:0])) else $error("address route");
    mode_route_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr && paddr == i2c_tx_pkg::OFF_SHARED0 && ctrl.iface_enable
        |=> $stable(sar) && mode == $past(pwdata[7:0])) else $error("mode route");
    start_req_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr && paddr == i2c_tx_pkg::OFF_CTRL && w.iface_enable && w.master_sel && w.tx_sel
        && w.bus_busy && !w.start_stop_ctl && !busy_s2 |=> $changed(start_tgl))
        else $error("start not requested");
    stop_req_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr && paddr == i2c_tx_pkg::OFF_CTRL && w.iface_enable && !w.bus_busy
        && !w.start_stop_ctl && busy_s2 |=> $changed(stop_tgl)) else $error("stop lost");
    nack_halt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr && paddr == i2c_tx_pkg::OFF_SHARED1 && halted |=> $stable(send_tgl))
        else $error("send after nack");
    pin_release_a: assert property (@(posedge clk_link) disable iff (!rstn)
        !en_l |-> !scl_oe && !sda_oe) else $error("pins driven while off");
    rate_std_a: assert property (@(posedge clk_link) disable iff (!rstn)
        cfg_s2[3] && cfg_s2[2:0] == i2c_tx_pkg::CLK_SEL_STD && tick && $stable(cfg_s2)
        |=> qcnt == i2c_tx_pkg::QTR_STD) else $error("wrong 100 kHz quarter");
    no_pause_a: assert property (@(posedge clk_link) disable iff (!rstn)
        st == i2c_tx_pkg::L_BIT && fmt_std && bitn == 4'h7 && ph == i2c_tx_pkg::PH_LAST
        && tick |=> st == i2c_tx_pkg::L_BIT && bitn == 4'h8) else $error("pause before ack");
    raw_end_a: assert property (@(posedge clk_link) disable iff (!rstn)
        st == i2c_tx_pkg::L_BIT && !fmt_std && bitn == 4'h7 && ph == i2c_tx_pkg::PH_LAST
        && tick |=> st == i2c_tx_pkg::L_HOLD) else $error("raw frame length");
    start_seen_c: cover property (@(posedge clk_sys) disable iff (!rstn) start_evt);
    byte_done_c: cover property (@(posedge clk_sys) disable iff (!rstn) byte_evt && ack_s2);
    stop_done_c: cover property (@(posedge clk_link) disable iff (!rstn) $fell(busy));

endmodule : i2c_tx_ctl

// [tb/eeprom_slave_model.sv]
`timescale 1ns/100ps
// slave memory stand-in on a pulled-up bus: acks every byte unless told to refuse
module eeprom_slave_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack,
    output logic      ack_oe
);
    int         cnt       = 0;
    int         starts    = 0;
    int         stops     = 0;
    int         bytes     = 0;
    logic [7:0] shifter   = 8'h00;
    logic [7:0] last_byte = 8'h00;

    initial ack_oe = 1'b0;

    // conditions: sda moving while scl is high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            starts++;
            cnt = 0;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            stops++;
            cnt = 0;
        end
    end

    // ninth fall ends data bit 8, so the ack slot opens; tenth fall closes it
    always @(negedge scl) begin
        cnt = (cnt == 9) ? 1 : cnt + 1;
        ack_oe <= (cnt == 9) && !nack;
    end

    // bits sampled on scl rise, byte complete when the ack slot is clocked
    always @(posedge scl) begin
        if (cnt >= 1 && cnt <= 8)
            shifter = {shifter[6:0], sda};
        if (cnt == 9) begin
            last_byte = shifter;
            bytes++;
        end
    end
endmodule : eeprom_slave_model

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
    logic        clk_sys  = 1'b0;
    logic        clk_link = 1'b0;
    logic        rstn     = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic        nack     = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, scl_out, scl_oe, sda_out, sda_oe, ack_oe;
    logic [7:0]  d;
    int          errors = 0;
    int          checks_done = 0;
    int          n;
    realtime     t_last = 0, p_min = 1.0e9, p_max = 0;
    // open-drain wires with pull-ups
    wire         scl_w = ~scl_oe;
    wire         sda_w = ~(sda_oe | ack_oe);

    initial forever #12.5 clk_sys = ~clk_sys;
    // odd offset keeps the link edges clear of the system edges
    initial begin
        #1.7;
        forever #3 clk_link = ~clk_link;
    end

    i2c_tx_ctl i2c_tx_ctl_i (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .clk_link(clk_link), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
    eeprom_slave_model eeprom_slave_model_i (.scl(scl_w), .sda(sda_w), .nack(nack),
        .ack_oe(ack_oe));

    function automatic logic [7:0] ctrl(input logic ie, input logic busy);
        return {1'b1, ie, 3'b111, busy, 2'b00};
    endfunction : ctrl

    // serial bit period asked for by the standard rate selection
    function automatic realtime scl_period();
        return 1.0e9 / i2c_tx_pkg::SCL_STD_HZ;
    endfunction : scl_period

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one apb transfer; read data taken at the edge that samples pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic poll(input int pos, input logic val);
        int k;
        k = 0;
        do begin
            apb(1'b0, i2c_tx_pkg::OFF_CTRL, 8'h00);
            k++;
        end while (rd[pos] !== val && k < 2000);
        check(rd[pos], val, "control poll");
    endtask : poll

    task automatic complete_run();
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // rise-to-rise spacing inside each frame
    always @(posedge scl_w) begin
        if (eeprom_slave_model_i.cnt inside {[2:9]}) begin
            if ($realtime - t_last < p_min)
                p_min = $realtime - t_last;
            if ($realtime - t_last > p_max)
                p_max = $realtime - t_last;
        end
        t_last = $realtime;
    end

    // watchdog, well beyond the few frames sent
    initial begin
        #2_000_000;
        errors++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h976907ad));
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        apb(1'b0, i2c_tx_pkg::OFF_CTRL, 8'h00);
        check(rd, {24'h0, i2c_tx_pkg::REG_RST}, "control reset value");
        apb(1'b1, i2c_tx_pkg::OFF_SHARED1, 8'h01);
        apb(1'b1, i2c_tx_pkg::OFF_CTRL, 8'h80);
        d = 8'($urandom);
        apb(1'b1, i2c_tx_pkg::OFF_SHARED0, d);
        apb(1'b0, i2c_tx_pkg::OFF_SHARED0, 8'h00);
        check(rd, {24'h0, d}, "mode register");
        apb(1'b1, i2c_tx_pkg::OFF_CTRL, 8'h00);
        apb(1'b0, i2c_tx_pkg::OFF_SHARED1, 8'h00);
        check(rd[0], 1'b1, "extended format bit");
        apb(1'b1, i2c_tx_pkg::OFF_SHARED1, 8'h00);
        apb(1'b1, i2c_tx_pkg::OFF_SHARED0, 8'h00);
        apb(1'b1, 8'h14, 8'hff);
        apb(1'b0, 8'h14, 8'h00);
        check(rd, 32'h0, "unmapped read");
        // standard rate, continuous transfer, ack check on, interrupt off
        apb(1'b1, i2c_tx_pkg::OFF_TIMER, 8'(1 << i2c_tx_pkg::RANGE_BIT));
        apb(1'b1, i2c_tx_pkg::OFF_CTRL, 8'h80);
        d = {2'b00, i2c_tx_pkg::CLK_SEL_STD, 3'b000};
        apb(1'b1, i2c_tx_pkg::OFF_SHARED0, d);
        apb(1'b1, i2c_tx_pkg::OFF_CTRL, 8'h89);
        poll(2, 1'b0);
        // counted from here: lines settling out of reset may look like a condition
        n = eeprom_slave_model_i.starts;
        apb(1'b1, i2c_tx_pkg::OFF_CTRL, ctrl(1'b0, 1'b1));
        poll(1, 1'b1);
        check(rd[2], 1'b1, "busy after start");
        check(irq, 1'b0, "interrupt masked");
        check(eeprom_slave_model_i.starts, n + 1, "start on the wire");
        check({pslverr, scl_out, sda_out}, 3'b000, "fixed outputs");
        for (int i = 0; i < 4; i++) begin
            nack <= (i == 3);
            d = 8'($urandom);
            apb(1'b1, i2c_tx_pkg::OFF_CTRL, ctrl(1'b1, 1'b1));
            apb(1'b1, i2c_tx_pkg::OFF_SHARED1, d);
            n = 0;
            while (irq !== 1'b1 && n < 6000) begin
                @(posedge clk_sys);
                n++;
            end
            check(irq, 1'b1, "byte done interrupt");
            check(eeprom_slave_model_i.last_byte, d, "byte on wire");
            apb(1'b0, i2c_tx_pkg::OFF_STAT, 8'h00);
            check(rd[0], (i == 3), "acknowledge bit");
        end
        nack <= 1'b0;
        // after a refusal a new byte must stay off the wire
        n = eeprom_slave_model_i.bytes;
        apb(1'b1, i2c_tx_pkg::OFF_CTRL, ctrl(1'b1, 1'b1));
        apb(1'b1, i2c_tx_pkg::OFF_SHARED1, 8'h5a);
        repeat (4000) @(posedge clk_sys);
        check(eeprom_slave_model_i.bytes, n, "halted transfer");
        check(irq, 1'b0, "no interrupt while halted");
        n = eeprom_slave_model_i.stops;
        apb(1'b1, i2c_tx_pkg::OFF_CTRL, ctrl(1'b0, 1'b0));
        poll(2, 1'b0);
        check(eeprom_slave_model_i.stops, n + 1, "stop on the wire");
        check({scl_w, sda_w}, 2'b11, "bus released");
        apb(1'b1, i2c_tx_pkg::OFF_STAT, 8'h00);
        apb(1'b0, i2c_tx_pkg::OFF_STAT, 8'h00);
        check(rd, 32'h0, "ack bit cleared");
        check(p_min > scl_period() - 30.0, 1'b1, "short bit");
        check(p_max < scl_period() + 30.0, 1'b1, "long bit");
        complete_run();
    end
endmodule : testbench
